// >>> rtl/audio_serial_map.svh
// Register offsets, field positions, codes and counts of the audio port.
// Assumes byte addresses on a 6-bit register port with 16-bit data.
`ifndef AUDIO_SERIAL_MAP_SVH
`define AUDIO_SERIAL_MAP_SVH

`define OFS_CTRL_MAIN 6'h00
`define OFS_CTRL_IRQ  6'h04
`define OFS_STATUS    6'h08
`define OFS_DATA      6'h0C
`define OFS_CRC_POLY  6'h10
`define OFS_RX_CRC    6'h14
`define OFS_TX_CRC    6'h18
`define OFS_AUD_CFG   6'h1C
`define OFS_AUD_PSC   6'h20

`define CI_RX_DMA  0
`define CI_TX_DMA  1
`define CI_ERR_IE  5
`define CI_RXNE_IE 6
`define CI_TXE_IE  7

`define ST_RXNE   0
`define ST_TXE    1
`define ST_CHSIDE 2
`define ST_UDR    3
`define ST_OVR    6
`define ST_BUSY   7

`define CF_CHLEN   0
`define CF_DLEN_LO 1
`define CF_DLEN_HI 2
`define CF_STD_LO  4
`define CF_STD_HI  5
`define CF_ROLE_LO 8
`define CF_ROLE_HI 9
`define CF_EN      10
`define CF_MODE    11

`define STD_PHILIPS 2'h0
`define STD_MSB     2'h1
`define STD_LSB     2'h2
`define STD_PCM     2'h3
`define ROLE_SLV_TX 2'h0
`define DLEN_16     2'h0

`define ZERO16    16'h0000
`define BIT_FIRST 6'h00
`define BIT_ONE   6'h01
`define BIT_HALF  6'h10
`define BIT_PRE   6'h3F
`define LAST16    6'h0F
`define LAST32    6'h1F

`endif

// >>> rtl/audio_serial_pkg.sv
// Types shared by the audio port: bus request and the module state.
// Assumes the offsets and field positions of audio_serial_map.svh.
`default_nettype none

package audio_serial_pkg;

  typedef struct packed {
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef enum logic [2:0] {
    LINK_OFF, LINK_SYNC, LINK_RUN, LINK_DRAIN, LINK_HALT
  } link_t;

  typedef struct packed {
    logic [2:0]  sck_s;
    logic [1:0]  ws_s;
    logic [1:0]  sd_s;
    logic        ws_r;
    logic        ws_f;
    link_t       link;
    logic [15:0] ctrl_main;
    logic [15:0] ctrl_irq;
    logic [15:0] cfg;
    logic [15:0] psc;
    logic [15:0] crc_poly;
    logic [15:0] tx_buf;
    logic [15:0] tx_sh;
    logic [15:0] rx_buf;
    logic [15:0] rx_sh;
    logic [5:0]  tx_idx;
    logic [5:0]  rx_idx;
    logic        slot_ch;
    logic        txe;
    logic        rxne;
    logic        chside;
    logic        udr;
    logic        ovr;
    logic        armed;
    logic        busy;
    logic [15:0] rd_data;
    logic        sd_out;
    logic        sd_oe;
    logic        irq;
    logic        tx_dreq;
    logic        rx_dreq;
  } state_t;

endpackage : audio_serial_pkg

`default_nettype wire

// >>> rtl/audio_serial_slave.sv
// Slave audio serial port: transmit and receive paths, flags, registers.
// Assumes an external master drives bit clock and word select; all pins
// are sampled by clk, which must run well above the bit clock.
// Behaviour
// - A loaded slave transmitter starts only when the master clocks a word.
// - At a word's first bit, data moves to the shift register, then out.
// - Moving a word into the shifter sets tx empty; its enable raises irq.
// - No new word by the next load time sets the underrun flag.
// - Channel side comes from the master's word select level.
// - In justified formats the first written word goes to the left channel.
// - A stopping transmitter drops busy only after tx empty is high.
// - A full receive buffer sets rx not empty; a data read clears it.
// - Received audio reaches the buffer in 16-bit units, one or two a slot.
// - A data write clears tx empty; it reads zero while the port is off.
// - Busy shows communication in progress, set and cleared by hardware.
// - In slave mode busy drops for one bit clock in each word.
// - Busy clears once the port is off and the current word is done.
// - In receive, channel side records the channel of each captured word.
// - After an error the link halts until the port is disabled and enabled.
// - Channel side reads zero in the pulse framed format.
// - Error flags with the error enable raise the interrupt.
// - Underrun acts only in audio mode; a status read clears it.
// - A word arriving while the buffer is full sets overrun and is lost.
// - Overrun clears on a status read followed by a data read.
// - DMA requests follow the buffer flags; the rx and tx CRC registers read zero.
//
// Chosen here: the address-and-strobe port.
`default_nettype none

`include "audio_serial_map.svh"

module audio_serial_slave (
  input  wire logic                       clk,        // System clock
  input  wire logic                       rst_b,      // Async reset
  input  wire audio_serial_pkg::bus_req_t bus,        // Register request
  output var  logic [15:0]                rd_data,    // Read data, next cycle
  input  wire logic                       sck,        // Bit clock pin
  input  wire logic                       ws,         // Word select pin
  input  wire logic                       sd_in,      // Serial data in
  output var  logic                       sd_out,     // Serial data out
  output var  logic                       sd_oe,      // Data pin drive
  output var  logic                       irq,        // Interrupt request
  output var  logic                       tx_dma_req, // Transmit DMA request
  output var  logic                       rx_dma_req  // Receive DMA request
);
  import audio_serial_pkg::*;

  state_t      r;
  state_t      n;
  logic        rise, fall, en, en_n, is_tx, two_half, lsb_pad;
  logic        start_t, start_r, act_t, act_r, ld, cap;
  logic        wdt, rdd, rds, rx_free;
  logic        txe_set, txe_clr, rxne_set, rxne_clr;
  logic        udr_set, udr_clr, ovr_set, ovr_clr;
  logic [1:0]  std;
  logic [5:0]  last, tidx, ridx;
  logic [15:0] stat, rmux;

  ////////////////////////////////////////////////////////////////////////
  // A pulse format restarts only on the rising frame pulse
  function automatic logic ws_edge(input logic nw, input logic ow,
                                   input logic [1:0] sd);
    ws_edge = (nw != ow) && (sd != `STD_PCM || nw);
  endfunction : ws_edge

  // Left is zero; in the standard format left is word select low
  function automatic logic chan_of(input logic w, input logic [1:0] sd);
    chan_of = (sd == `STD_PHILIPS) ? w : ~w;
  endfunction : chan_of

  // Standard format puts the first bit one clock after the select edge
  function automatic logic [5:0] next_idx(input logic nw, input logic ow,
                                          input logic [1:0] sd,
                                          input logic [5:0] cur);
    if (ws_edge(nw, ow, sd)) begin
      next_idx = (sd == `STD_PHILIPS) ? `BIT_PRE : `BIT_FIRST;
    end else begin
      next_idx = cur + `BIT_ONE;
    end
  endfunction : next_idx

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n        = r;
    txe_set  = 1'b0;
    txe_clr  = 1'b0;
    rxne_set = 1'b0;
    rxne_clr = 1'b0;
    udr_set  = 1'b0;
    udr_clr  = 1'b0;
    ovr_set  = 1'b0;
    ovr_clr  = 1'b0;

    en       = r.cfg[`CF_EN] & r.cfg[`CF_MODE];
    std      = r.cfg[`CF_STD_HI:`CF_STD_LO];
    is_tx    = r.cfg[`CF_ROLE_HI:`CF_ROLE_LO] == `ROLE_SLV_TX;
    last     = r.cfg[`CF_CHLEN] ? `LAST32 : `LAST16;
    two_half = r.cfg[`CF_CHLEN] &&
               r.cfg[`CF_DLEN_HI:`CF_DLEN_LO] != `DLEN_16;
    lsb_pad  = r.cfg[`CF_CHLEN] && !two_half && std == `STD_LSB;

    wdt = bus.wr && bus.addr == `OFS_DATA;
    rdd = bus.rd && bus.addr == `OFS_DATA;
    rds = bus.rd && bus.addr == `OFS_STATUS;

    // Only the second stage of the select and data chains is looked at; bit clock edges use stages two and three
    n.sck_s = {r.sck_s[1:0], sck};
    n.ws_s  = {r.ws_s[0], ws};
    n.sd_s  = {r.sd_s[0], sd_in};
    rise    = r.sck_s[1] & ~r.sck_s[2];
    fall    = r.sck_s[2] & ~r.sck_s[1];

    //////////////////////////////////////////////////////////////////////
    // Register port
    if (bus.wr) begin
      case (bus.addr)
        `OFS_CTRL_MAIN: n.ctrl_main = bus.wdata;
        `OFS_CTRL_IRQ:  n.ctrl_irq  = bus.wdata;
        `OFS_CRC_POLY:  n.crc_poly  = bus.wdata;
        `OFS_AUD_CFG:   n.cfg       = bus.wdata;
        `OFS_AUD_PSC:   n.psc       = bus.wdata;
        `OFS_DATA: begin
          n.tx_buf = bus.wdata;
          txe_clr  = 1'b1;
        end
        default: ;
      endcase
    end

    stat              = `ZERO16;
    stat[`ST_RXNE]    = r.rxne;
    stat[`ST_TXE]     = en & r.txe;
    stat[`ST_CHSIDE]  = r.chside & (std != `STD_PCM);
    stat[`ST_UDR]     = r.udr;
    stat[`ST_OVR]     = r.ovr;
    stat[`ST_BUSY]    = r.busy;

    case (bus.addr)
      `OFS_CTRL_MAIN: rmux = r.ctrl_main;
      `OFS_CTRL_IRQ:  rmux = r.ctrl_irq;
      `OFS_STATUS:    rmux = stat;
      `OFS_DATA:      rmux = r.rx_buf;
      `OFS_CRC_POLY:  rmux = r.crc_poly;
      `OFS_AUD_CFG:   rmux = r.cfg;
      `OFS_AUD_PSC:   rmux = r.psc;
      default:        rmux = `ZERO16;
    endcase
    n.rd_data = bus.rd ? rmux : `ZERO16;

    if (rds) begin
      udr_clr = 1'b1;
      if (r.ovr) begin
        n.armed = 1'b1;
      end
    end
    if (rdd) begin
      rxne_clr = 1'b1;
      ovr_clr  = r.armed;
      n.armed  = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////
    // Enable sequencing; edge handling below may override
    case (r.link)
      LINK_OFF:  if (en) n.link = LINK_SYNC;
      LINK_SYNC: if (!en) n.link = LINK_OFF;
      LINK_HALT: if (!en) n.link = LINK_OFF;
      LINK_RUN:  if (!en) n.link = LINK_DRAIN;
      LINK_DRAIN: ;
      default:   n.link = LINK_OFF;
    endcase
    if (r.link == LINK_OFF || r.link == LINK_HALT) begin
      n.busy = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////
    // Transmit: data changes after the falling bit clock edge
    if (fall) begin
      n.ws_f = r.ws_s[1];
    end
    tidx    = next_idx(r.ws_s[1], r.ws_f, std, r.tx_idx);
    start_t = fall && is_tx && en && r.link == LINK_SYNC &&
              ws_edge(r.ws_s[1], r.ws_f, std) &&
              !chan_of(r.ws_s[1], std);
    act_t   = fall && is_tx &&
              (start_t || r.link == LINK_RUN || r.link == LINK_DRAIN);
    ld      = act_t &&
              ((tidx == `BIT_FIRST && !lsb_pad) ||
               (tidx == `BIT_HALF && (two_half || lsb_pad)));

    if (act_t) begin
      n.tx_idx = tidx;
      n.busy   = tidx != `BIT_FIRST;
      if (start_t) begin
        n.link = LINK_RUN;
      end
      if (r.link == LINK_DRAIN && tidx == `BIT_FIRST && r.txe) begin
        n.link  = LINK_OFF;
        n.busy  = 1'b0;
        n.tx_sh = `ZERO16;
      end else if (ld) begin
        if (r.txe && !wdt) begin
          udr_set = 1'b1;
          n.link  = LINK_HALT;
          n.busy  = 1'b0;
          n.tx_sh = `ZERO16;
        end else begin
          // A write in the load cycle goes straight to the shifter when tx empty is set
          n.tx_sh  = r.txe ? bus.wdata : r.tx_buf;
          txe_set  = r.txe || !wdt;
          n.chside = chan_of(r.ws_s[1], std);
        end
      end else if (tidx == `BIT_FIRST || tidx > last) begin
        n.tx_sh = `ZERO16;
      end else begin
        n.tx_sh = {r.tx_sh[14:0], 1'b0};
      end
    end

    //////////////////////////////////////////////////////////////////////
    // Receive: data is sampled on the rising bit clock edge
    if (rise) begin
      n.ws_r = r.ws_s[1];
    end
    ridx    = next_idx(r.ws_s[1], r.ws_r, std, r.rx_idx);
    start_r = rise && !is_tx && en && r.link == LINK_SYNC &&
              ws_edge(r.ws_s[1], r.ws_r, std) &&
              !chan_of(r.ws_s[1], std);
    act_r   = rise && !is_tx &&
              (start_r || r.link == LINK_RUN || r.link == LINK_DRAIN);
    cap     = act_r &&
              ((ridx == `LAST16 && !lsb_pad) ||
               (ridx == `LAST32 && (two_half || lsb_pad)));
    // A word landing in the cycle of a data read is not an overrun
    rx_free = !r.rxne || rdd;

    if (act_r) begin
      n.rx_idx = ridx;
      n.busy   = ridx != `BIT_FIRST;
      n.rx_sh  = {r.rx_sh[14:0], r.sd_s[1]};
      if (start_r) begin
        n.link = LINK_RUN;
      end
      if (cap) begin
        if (!rx_free) begin
          ovr_set = 1'b1;
          n.link  = LINK_HALT;
          n.busy  = 1'b0;
        end else begin
          n.rx_buf = {r.rx_sh[14:0], r.sd_s[1]};
          rxne_set = 1'b1;
          n.chside = r.slot_ch;
        end
      end
      // Slot channel is taken after capture: in the standard format the
      // select edge and the last bit of a short slot share one clock
      if (ws_edge(r.ws_s[1], r.ws_r, std)) begin
        n.slot_ch = chan_of(r.ws_s[1], std);
      end
      if (r.link == LINK_DRAIN && ridx == last) begin
        n.link = LINK_OFF;
        n.busy = 1'b0;
      end
    end

    //////////////////////////////////////////////////////////////////////
    // Flags: a hardware set wins over a software clear
    n.txe  = txe_set | (r.txe & ~txe_clr);
    n.rxne = rxne_set | (r.rxne & ~rxne_clr);
    n.udr  = udr_set | (r.udr & ~udr_clr);
    n.ovr  = ovr_set | (r.ovr & ~ovr_clr);
    if (ovr_set) begin
      n.armed = 1'b0;
    end

    en_n      = n.cfg[`CF_EN] & n.cfg[`CF_MODE];
    n.sd_out  = n.tx_sh[15];
    n.sd_oe   = is_tx && n.link != LINK_OFF;
    n.irq     = (en_n & n.txe & n.ctrl_irq[`CI_TXE_IE]) |
                (n.rxne & n.ctrl_irq[`CI_RXNE_IE]) |
                ((n.udr | n.ovr) & n.ctrl_irq[`CI_ERR_IE]);
    n.tx_dreq = en_n & is_tx & n.txe & n.ctrl_irq[`CI_TX_DMA];
    n.rx_dreq = n.rxne & n.ctrl_irq[`CI_RX_DMA];
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r      <= '0;
      r.link <= LINK_OFF;
      r.txe  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign rd_data    = r.rd_data;
  assign sd_out     = r.sd_out;
  assign sd_oe      = r.sd_oe;
  assign irq        = r.irq;
  assign tx_dma_req = r.tx_dreq;
  assign rx_dma_req = r.rx_dreq;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_txe_hidden_off: assert property (
    rds && !en |=> !rd_data[`ST_TXE])
    else $error("tx empty visible while port disabled");

  a_data_wr_clr: assert property (
    wdt && !txe_set |=> !r.txe)
    else $error("data write did not clear tx empty");

  a_load_sets_txe: assert property (
    ld && !udr_set && !wdt && !(r.link == LINK_DRAIN && r.txe)
    |=> r.txe && r.tx_sh == $past(r.tx_buf))
    else $error("word load did not set tx empty");

  a_rxne_rd_clr: assert property (
    rdd && !rxne_set |=> !r.rxne)
    else $error("data read did not clear rx not empty");

  a_udr_halts: assert property (
    udr_set |=> r.udr && r.link == LINK_HALT)
    else $error("underrun not flagged or link not halted");

  a_ovr_keeps_buf: assert property (
    cap && !rx_free |=> r.ovr && $stable(r.rx_buf))
    else $error("overrun lost the buffered word");

  a_ovr_order: assert property (
    r.ovr && rdd && !r.armed && !ovr_set |=> r.ovr)
    else $error("overrun cleared without a status read first");

  a_err_irq: assert property (
    (r.udr || r.ovr) && r.ctrl_irq[`CI_ERR_IE] |-> irq)
    else $error("error flag without interrupt");

  a_busy_off: assert property (
    r.link == LINK_OFF |-> !r.busy)
    else $error("busy high with link off");

  a_halt_holds: assert property (
    r.link == LINK_HALT && en |=> r.link == LINK_HALT)
    else $error("link left halt without disable");

  c_tx_load: cover property (ld && !udr_set);
  c_underrun: cover property (udr_set);
  c_rx_cap: cover property (cap && rx_free);
  c_overrun: cover property (ovr_set);
  c_drain_off: cover property (r.link == LINK_DRAIN ##1 r.link == LINK_OFF);

endmodule : audio_serial_slave

`default_nettype wire

// >>> testbench/audio_master_model.sv
// Behavioural audio serial master: bit clock, word select and slot data.
// Assumes 16-bit slots, MSB first, data changed on the falling clock edge,
// a 160 ns bit clock, and a line resolved by the bench from all drivers.
`default_nettype none

module audio_master_model (
  input  wire logic        run,     // Frames run while high
  input  wire logic [15:0] pattern, // Slot s carries pattern plus s
  input  wire logic        sd_line, // Resolved serial data line
  output var  logic        sck,     // Bit clock
  output var  logic        ws,      // Word select, high on left slots
  output var  logic        sd_drv   // Data bit toward the slave
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] cap [0:15];
  logic [15:0] shreg;
  logic [15:0] word;
  logic        active;
  int          slot;

  ////////////////////////////////////////////////////////////////////////
  // Clock stands low between frames. A frame opens on a right slot so the
  // slave sees word select rise into the left channel on slot one.
  initial begin
    sck = 1'b0;
    ws = 1'b0;
    sd_drv = 1'b0;
    shreg = 16'h0000;
    active = 1'b0;
    slot = 0;
    forever begin
      wait (run === 1'b1);
      // Run arrives on a clock edge; keep every pin change off the edges
      #3;
      active = 1'b1;
      while (run === 1'b1) begin
        word = pattern + 16'(slot);
        for (int b = 15; b >= 0; b--) begin
          sck = 1'b0;
          ws = slot[0];
          sd_drv = word[b];
          #80;
          sck = 1'b1;
          shreg = {shreg[14:0], sd_line};
          #80;
        end
        cap[slot[3:0]] = shreg;
        slot = slot + 1;
      end
      sck = 1'b0;
      slot = 0;
      active = 1'b0;
    end
  end

endmodule : audio_master_model

`default_nettype wire

// >>> testbench/test_audio_serial_slave.sv
// Bench for the slave audio port: registers, transmit, receive, errors.
// Assumes audio_master_model as the far side and the register map header.
`default_nettype none

`include "audio_serial_map.svh"

module test_audio_serial_slave;
  import audio_serial_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [15:0] PAT = 16'hA5C0;
  localparam bus_req_t IDLE = '{6'h00, 16'h0000, 1'b0, 1'b0};

  logic        clk;
  logic        rst_b;
  bus_req_t    bus;
  logic [15:0] rd_data;
  logic        sck;
  logic        ws;
  logic        sd_in;
  logic        sd_out;
  logic        sd_oe;
  logic        irq;
  logic        tx_dma_req;
  logic        rx_dma_req;
  logic        m_run;
  logic        m_drive;
  logic        m_sd;
  logic [15:0] st;
  logic [15:0] d;
  logic        c1;
  int          miscompares;
  int          tests_run;

  // Undriven line shows the inverse of the last bit, never a stale copy
  assign sd_in = sd_oe ? sd_out : (m_drive ? m_sd : ~m_sd);

  audio_serial_slave u_dut (
    .clk        (clk),
    .rst_b      (rst_b),
    .bus        (bus),
    .rd_data    (rd_data),
    .sck        (sck),
    .ws         (ws),
    .sd_in      (sd_in),
    .sd_out     (sd_out),
    .sd_oe      (sd_oe),
    .irq        (irq),
    .tx_dma_req (tx_dma_req),
    .rx_dma_req (rx_dma_req)
  );

  audio_master_model u_master (
    .run     (m_run),
    .pattern (PAT),
    .sd_line (sd_in),
    .sck     (sck),
    .ws      (ws),
    .sd_drv  (m_sd)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask : check_reg

  task automatic check_pin(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: level %b, want %b", $time, got, exp);
    end
  endtask : check_pin

  task automatic reg_wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus <= IDLE;
  endtask : reg_wr

  task automatic reg_rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus <= IDLE;
    #1 v = rd_data;
  endtask : reg_rd

  // Reads status until the bit rises, bounded so a dead link cannot hang
  task automatic poll(input int b);
    int n;
    n = 0;
    st = 16'h0000;
    while (st[b] !== 1'b1 && n < 500) begin
      reg_rd(`OFS_STATUS, st);
      n++;
    end
    check_pin(st[b], 1'b1);
  endtask : poll

  // Master finishes the slot it is in once the count is reached
  task automatic stop_at(input int n);
    int k;
    for (k = 0; k < 3000 && u_master.slot != n; k++) @(posedge clk);
    m_run <= 1'b0;
    for (k = 0; k < 3000 && u_master.active; k++) @(posedge clk);
  endtask : stop_at

  task automatic print_verdict();
    $display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    bus = IDLE;
    m_run = 1'b0;
    m_drive = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a <= 'h24; a += 4) begin
      reg_rd(6'(a), d);
      check_reg(d, 16'h0000);
    end
    reg_wr(`OFS_CRC_POLY, 16'h1234);
    reg_wr(`OFS_TX_CRC, 16'hFFFF);
    reg_rd(`OFS_CRC_POLY, d);
    check_reg(d, 16'h1234);
    reg_rd(`OFS_TX_CRC, d);
    check_reg(d, 16'h0000);
    // Transmit, MSB-justified 16/16, then a deliberate underrun
    reg_wr(`OFS_CTRL_IRQ, 16'h0082);
    reg_wr(`OFS_AUD_CFG, 16'h0C10);
    reg_rd(`OFS_STATUS, st);
    check_reg(st & 16'h00CB, 16'h0002);
    check_pin(irq, 1'b1);
    check_pin(tx_dma_req, 1'b1);
    reg_wr(`OFS_DATA, 16'h9A51);
    reg_rd(`OFS_STATUS, st);
    check_reg(st & 16'h0002, 16'h0000);
    check_pin(irq, 1'b0);
    check_pin(tx_dma_req, 1'b0);
    m_run <= 1'b1;
    poll(`ST_TXE);
    check_pin(sd_oe, 1'b1);
    reg_wr(`OFS_DATA, 16'h3C6E);
    stop_at(4);
    check_reg(u_master.cap[1], 16'h9A51);
    check_reg(u_master.cap[2], 16'h3C6E);
    reg_wr(`OFS_CTRL_IRQ, 16'h0020);
    reg_rd(`OFS_CTRL_IRQ, d);
    check_pin(irq, 1'b1);
    reg_rd(`OFS_STATUS, st);
    check_reg(st & 16'h0008, 16'h0008);
    reg_rd(`OFS_STATUS, st);
    check_reg(st & 16'h0008, 16'h0000);
    reg_wr(`OFS_AUD_CFG, 16'h0810);
    reg_rd(`OFS_STATUS, st);
    check_reg(st & 16'h0082, 16'h0000);
    check_pin(irq, 1'b0);
    check_pin(sd_oe, 1'b0);
    // Receive, then a deliberate overrun
    m_drive <= 1'b1;
    reg_wr(`OFS_CTRL_IRQ, 16'h0041);
    reg_wr(`OFS_AUD_CFG, 16'h0D10);
    m_run <= 1'b1;
    poll(`ST_RXNE);
    c1 = st[`ST_CHSIDE];
    check_pin(irq, 1'b1);
    check_pin(rx_dma_req, 1'b1);
    reg_rd(`OFS_DATA, d);
    check_reg(d, PAT + 16'h0001);
    reg_rd(`OFS_STATUS, st);
    check_reg(st & 16'h0001, 16'h0000);
    poll(`ST_RXNE);
    check_pin(st[`ST_CHSIDE], ~c1);
    // Channel side is one here, so the pulse format must hide it
    reg_wr(`OFS_AUD_CFG, 16'h0D30);
    reg_rd(`OFS_STATUS, d);
    check_reg(d & 16'h0004, 16'h0000);
    reg_wr(`OFS_AUD_CFG, 16'h0D10);
    reg_rd(`OFS_DATA, d);
    check_reg(d, PAT + 16'h0002);
    stop_at(5);
    reg_rd(`OFS_STATUS, st);
    check_reg(st & 16'h0041, 16'h0041);
    reg_rd(`OFS_STATUS, st);
    check_reg(st & 16'h0040, 16'h0040);
    reg_rd(`OFS_DATA, d);
    check_reg(d, PAT + 16'h0003);
    reg_rd(`OFS_STATUS, st);
    check_reg(st & 16'h0041, 16'h0000);
    // Pulse framed receive, then a disable that drains the last word
    reg_wr(`OFS_AUD_CFG, 16'h0800);
    reg_wr(`OFS_AUD_CFG, 16'h0D30);
    m_run <= 1'b1;
    poll(`ST_RXNE);
    check_reg(st & 16'h0004, 16'h0000);
    reg_rd(`OFS_DATA, d);
    check_reg(d, PAT + 16'h0001);
    reg_wr(`OFS_AUD_CFG, 16'h0930);
    stop_at(3);
    reg_rd(`OFS_STATUS, st);
    check_reg(st & 16'h0081, 16'h0001);
    reg_rd(`OFS_DATA, d);
    check_reg(d, PAT + 16'h0003);
    print_verdict();
  end

endmodule : test_audio_serial_slave

`default_nettype wire
